// [logic/gpio_interrupt_config.sv]
// Notes on behaviour
// RULE1 - Eight port D direction bits, 0 input, 1 output, reset to input.
// RULE2 - Enable bit makes the port A pin an interrupt source.
// RULE3 - No interrupt from a port A bit whose direction is output.
// RULE4 - Mask bit set blocks that pin from the interrupt controller.
// RULE5 - Type bit: 0 level-sensitive, 1 edge-sensitive detection.
// RULE6 - Polarity bit: 0 low level or falling edge, 1 high or rising.
// RULE7 - After reset: plain GPIO, unmasked, level-sensitive, active-low.
// RULE8 - Registers use bits 7:0 only; upper bits read zero, ignore writes.
// RULE9 - Raw interrupt condition before masking is readable per bit.
// RULE10 - Interrupt status after masking is readable per bit.
// RULE11 - Writing 1 clears a latched edge; all clear when not enabled.
// RULE12 - With debounce on, input accepted after two debounce clock periods.
`timescale 1ns/1ps
`default_nettype none

module gpio_interrupt_config #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic                            clk_i,
	input  wire logic                            rst_i,
	// Wishbone slave
	input  wire logic                            cyc_i,
	input  wire logic                            stb_i,
	input  wire logic                            we_i,
	input  wire logic [gpio_cfg_pkg::ADR_W-1:0]  adr_i,
	input  wire logic [3:0]                      sel_i,
	input  wire logic [gpio_cfg_pkg::DATA_W-1:0] dat_i,
	output logic      [gpio_cfg_pkg::DATA_W-1:0] dat_o,
	output logic                                 ack_o,
	// Pins and neighbours
	input  wire logic [W-1:0]                    port_a_i,
	input  wire logic [W-1:0]                    port_a_dir_i,
	input  wire logic                            db_clk_i,
	output logic      [W-1:0]                    port_d_dir_o,
	output logic      [W-1:0]                    edge_clear_o,
	// Interrupt status
	output logic      [W-1:0]                    raw_status_o,
	output logic      [W-1:0]                    masked_status_o,
	output logic                                 irq_o
);

	// ****************************************
	// Parameter check
	// ****************************************
	// Only the low byte of each word is implemented
	if (W < 1 || W > gpio_cfg_pkg::FIELD_W) begin : g_bad_w
		$error("W must lie between 1 and 8");
	end

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] pad(input logic [W-1:0] v);
		logic [31:0] r;
		r = gpio_cfg_pkg::RST_WORD;
		r[W-1:0] = v;
		return r;
	endfunction : pad

	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		return a == o;
	endfunction : hit

	// ****************************************
	// Registers
	// ****************************************
	logic          ack_ff;
	logic [31:0]   dat_ff;
	logic [W-1:0]  dir_d_ff;
	logic [W-1:0]  inten_ff;
	logic [W-1:0]  mask_ff;
	logic [W-1:0]  type_ff;
	logic [W-1:0]  pol_ff;
	logic [W-1:0]  deb_ff;
	logic [W-1:0]  raw_ff;
	logic [W-1:0]  msk_sts_ff;
	logic          irq_ff;
	logic [W-1:0]  eclr_ff;
	logic          db_s1_ff;
	logic          db_s2_ff;
	logic          db_s3_ff;
	logic [W-1:0]  samp1_ff;
	logic [W-1:0]  samp2_ff;
	logic [W-1:0]  filt_ff;
	logic [W-1:0]  prev_ff;

	// ****************************************
	// Bus decode
	// ****************************************
	wire logic         req      = cyc_i & stb_i;
	wire logic         take     = req & ~ack_ff;
	// Writes land on the edge where the master sees ack
	wire logic         wr_stb   = req & we_i & ack_ff & sel_i[0];
	wire logic         wr_dir   = wr_stb & hit(adr_i, gpio_cfg_pkg::OFS_DIR_D);
	wire logic         wr_en    = wr_stb & hit(adr_i, gpio_cfg_pkg::OFS_INT_EN);
	wire logic         wr_msk   = wr_stb & hit(adr_i, gpio_cfg_pkg::OFS_INT_MSK);
	wire logic         wr_typ   = wr_stb & hit(adr_i, gpio_cfg_pkg::OFS_INT_TYP);
	wire logic         wr_pol   = wr_stb & hit(adr_i, gpio_cfg_pkg::OFS_INT_POL);
	wire logic         wr_deb   = wr_stb & hit(adr_i, gpio_cfg_pkg::OFS_DEBOUNC);
	wire logic         wr_clr   = wr_stb & hit(adr_i, gpio_cfg_pkg::OFS_EDGE_CL);
	wire logic [W-1:0] wval     = dat_i[W-1:0];

	// Unmapped offsets and write-only words read as zero
	wire logic [31:0]  rd_mux   =
		hit(adr_i, gpio_cfg_pkg::OFS_DIR_D)   ? pad(dir_d_ff)   : // [RULE8]
		hit(adr_i, gpio_cfg_pkg::OFS_INT_EN)  ? pad(inten_ff)   :
		hit(adr_i, gpio_cfg_pkg::OFS_INT_MSK) ? pad(mask_ff)    :
		hit(adr_i, gpio_cfg_pkg::OFS_INT_TYP) ? pad(type_ff)    :
		hit(adr_i, gpio_cfg_pkg::OFS_INT_POL) ? pad(pol_ff)     :
		hit(adr_i, gpio_cfg_pkg::OFS_MSK_STS) ? pad(msk_sts_ff) : // [RULE10]
		hit(adr_i, gpio_cfg_pkg::OFS_RAW_STS) ? pad(raw_ff)     : // [RULE9]
		hit(adr_i, gpio_cfg_pkg::OFS_DEBOUNC) ? pad(deb_ff)     :
		gpio_cfg_pkg::RST_WORD;

	// ****************************************
	// Wishbone handshake
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			dat_ff <= gpio_cfg_pkg::RST_WORD;
		end else begin
			ack_ff <= take;
			if (take) begin
				dat_ff <= we_i ? gpio_cfg_pkg::RST_WORD : rd_mux;
			end
		end
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dir_d_ff <= W'(gpio_cfg_pkg::RST_FIELD); // [RULE1] [RULE7]
			inten_ff <= W'(gpio_cfg_pkg::RST_FIELD); // [RULE7]
			mask_ff  <= W'(gpio_cfg_pkg::RST_FIELD); // [RULE7]
			type_ff  <= W'(gpio_cfg_pkg::RST_FIELD); // [RULE7]
			pol_ff   <= W'(gpio_cfg_pkg::RST_FIELD); // [RULE7]
			deb_ff   <= W'(gpio_cfg_pkg::RST_FIELD);
		end else begin
			if (wr_dir) dir_d_ff <= wval; // [RULE1]
			if (wr_en)  inten_ff <= wval; // [RULE2]
			if (wr_msk) mask_ff  <= wval; // [RULE4]
			if (wr_typ) type_ff  <= wval; // [RULE5]
			if (wr_pol) pol_ff   <= wval; // [RULE6]
			if (wr_deb) deb_ff   <= wval; // [RULE12]
		end
	end

	// ****************************************
	// Debounce
	// ****************************************
	// Debounce clock is slow; it is sampled, not used as a clock
	wire logic         db_tick = db_s2_ff & ~db_s3_ff;
	wire logic [W-1:0] agree   = ~(samp1_ff ^ samp2_ff);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			db_s1_ff <= 1'b0;
			db_s2_ff <= 1'b0;
			db_s3_ff <= 1'b0;
			samp1_ff <= '0;
			samp2_ff <= '0;
			filt_ff  <= '0;
		end else begin
			db_s1_ff <= db_clk_i;
			db_s2_ff <= db_s1_ff;
			db_s3_ff <= db_s2_ff;
			if (db_tick) begin
				samp1_ff <= port_a_i;
				samp2_ff <= samp1_ff;
				filt_ff  <= (filt_ff & ~agree) | (samp1_ff & agree); // [RULE12]
			end
		end
	end

	// ****************************************
	// Interrupt detection
	// ****************************************
	wire logic [W-1:0] src   = (deb_ff & filt_ff) | (~deb_ff & port_a_i);
	// An output-direction bit can never raise a request
	wire logic [W-1:0] elig  = inten_ff & ~port_a_dir_i; // [RULE2] [RULE3]
	wire logic [W-1:0] act   = (pol_ff & src) | (~pol_ff & ~src); // [RULE6]
	wire logic [W-1:0] rise  = src & ~prev_ff;
	wire logic [W-1:0] fall  = ~src & prev_ff;
	wire logic [W-1:0] evt   = elig & type_ff &
		((pol_ff & rise) | (~pol_ff & fall)); // [RULE5] [RULE6]
	wire logic [W-1:0] clr   = wr_clr ? wval : '0; // [RULE11]
	// A new edge beats a clear in the same cycle
	wire logic [W-1:0] held  = evt | (raw_ff & ~clr); // [RULE11]
	wire logic [W-1:0] nxt_raw =
		elig & ((type_ff & held) | (~type_ff & act)); // [RULE5]
	wire logic [W-1:0] nxt_msk = nxt_raw & ~mask_ff; // [RULE4]

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prev_ff    <= '0;
			raw_ff     <= '0;
			msk_sts_ff <= '0;
			irq_ff     <= 1'b0;
			eclr_ff    <= '0;
		end else begin
			prev_ff    <= src;
			raw_ff     <= nxt_raw; // [RULE9]
			msk_sts_ff <= nxt_msk; // [RULE10]
			irq_ff     <= |nxt_msk; // [RULE4]
			eclr_ff    <= clr;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign dat_o           = dat_ff;
	assign ack_o           = ack_ff;
	assign port_d_dir_o    = dir_d_ff;
	assign edge_clear_o    = eclr_ff;
	assign raw_status_o    = raw_ff;
	assign masked_status_o = msk_sts_ff;
	assign irq_o           = irq_ff;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	ack_single_a: assert property (ack_o |=> !ack_o)
		else $error("ack held for more than one cycle");

	dir_write_a: assert property ( // [RULE1]
		wr_dir |=> port_d_dir_o == $past(wval))
		else $error("direction write not stored");

	enable_gate_a: assert property ( // [RULE2]
		(raw_ff & ~$past(inten_ff)) == '0)
		else $error("raw bit set while not enabled");

	output_block_a: assert property ( // [RULE3]
		(raw_ff & $past(port_a_dir_i)) == '0)
		else $error("interrupt from output pin");

	mask_gate_a: assert property ( // [RULE4]
		masked_status_o == (raw_ff & ~$past(mask_ff)) &&
		irq_o == |masked_status_o)
		else $error("mask not applied");

	level_track_a: assert property ( // [RULE5]
		(raw_ff & ~$past(type_ff)) ==
		($past(act & elig) & ~$past(type_ff)))
		else $error("level bit does not follow pin");

	sequence edge_seen_s;
		evt != '0;
	endsequence

	edge_latch_a: assert property ( // [RULE6]
		edge_seen_s |=> (raw_ff & $past(evt)) == $past(evt))
		else $error("edge not latched");

	reset_vals_a: assert property ( // [RULE7]
		$fell(rst_i) |-> inten_ff == '0 && mask_ff == '0 &&
		type_ff == '0 && pol_ff == '0 && dir_d_ff == '0)
		else $error("wrong value after reset");

	upper_zero_a: assert property ( // [RULE8]
		ack_o |-> dat_o[31:W] == '0)
		else $error("reserved bits not zero");

	sequence raw_read_s;
		take && !we_i && hit(adr_i, gpio_cfg_pkg::OFS_RAW_STS);
	endsequence

	raw_read_a: assert property ( // [RULE9]
		raw_read_s |=> ack_o && dat_o[W-1:0] == $past(raw_ff))
		else $error("raw status read wrong");

	sequence msk_read_s;
		take && !we_i && hit(adr_i, gpio_cfg_pkg::OFS_MSK_STS);
	endsequence

	msk_read_a: assert property ( // [RULE10]
		msk_read_s |=> ack_o && dat_o[W-1:0] == $past(msk_sts_ff))
		else $error("masked status read wrong");

	edge_clear_a: assert property ( // [RULE11]
		wr_clr |=> (raw_ff & $past(clr & type_ff & ~evt)) == '0)
		else $error("edge not cleared");

	debounce_step_a: assert property ( // [RULE12]
		$changed(filt_ff) |-> $past(db_tick))
		else $error("debounce moved without tick");

	// ****************************************
	// Assertions on bus writes and reset
	// ****************************************
	// Each write lands on the ack edge and shows one cycle later

	sequence bus_take_s;
		take;
	endsequence

	ack_answer_a: assert property (
		bus_take_s |=> ack_o)
		else $error("access not answered in one cycle");

	enable_write_a: assert property ( // [RULE2]
		wr_en |=> inten_ff == $past(wval))
		else $error("enable write not stored");

	mask_write_a: assert property ( // [RULE4]
		wr_msk |=> mask_ff == $past(wval))
		else $error("mask write not stored");

	type_write_a: assert property ( // [RULE5]
		wr_typ |=> type_ff == $past(wval))
		else $error("type write not stored");

	pol_write_a: assert property ( // [RULE6]
		wr_pol |=> pol_ff == $past(wval))
		else $error("polarity write not stored");

	deb_write_a: assert property ( // [RULE12]
		wr_deb |=> deb_ff == $past(wval))
		else $error("debounce write not stored");

	clear_pulse_a: assert property ( // [RULE11]
		wr_clr |=> edge_clear_o == $past(wval))
		else $error("clear pulse wrong");

	write_data_a: assert property ( // [RULE8]
		ack_o && $past(we_i) |-> dat_o == '0)
		else $error("write answer carries data");

	reset_outs_a: assert property ( // [RULE7]
		$fell(rst_i) |-> !irq_o && !ack_o &&
		raw_status_o == '0 && masked_status_o == '0)
		else $error("outputs not clear after reset");

endmodule : gpio_interrupt_config

`default_nettype wire

// [include/gpio_cfg_pkg.sv]
`default_nettype none

package gpio_cfg_pkg;

	// ****************************************
	// Bus geometry
	// ****************************************
	localparam int ADR_W   = 8;
	localparam int DATA_W  = 32;
	localparam int FIELD_W = 8;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] OFS_DIR_D   = 8'h28;
	localparam logic [7:0] OFS_INT_EN  = 8'h30;
	localparam logic [7:0] OFS_INT_MSK = 8'h34;
	localparam logic [7:0] OFS_INT_TYP = 8'h38;
	localparam logic [7:0] OFS_INT_POL = 8'h3c;
	localparam logic [7:0] OFS_MSK_STS = 8'h40;
	localparam logic [7:0] OFS_RAW_STS = 8'h44;
	localparam logic [7:0] OFS_DEBOUNC = 8'h48;
	localparam logic [7:0] OFS_EDGE_CL = 8'h4c;

	// ****************************************
	// Values after reset
	// ****************************************
	localparam logic [7:0] RST_FIELD = 8'h00;
	localparam logic [31:0] RST_WORD = 32'h00000000;

	// ****************************************
	// Field encodings
	// ****************************************
	localparam logic DIR_INPUT   = 1'b0;
	localparam logic TYPE_LEVEL  = 1'b0;
	localparam logic POL_LOW     = 1'b0;

endpackage : gpio_cfg_pkg

`default_nettype wire

// [tb/pin_model.sv]
`timescale 1ns/1ps
`default_nettype none

module pin_model (
	// Clock
	input  wire logic       clk_i,
	// Requested pin state
	input  wire logic [7:0] lvl_i,
	input  wire logic [7:0] dir_i,
	// Pins toward the block
	output logic      [7:0] pin_o,
	output logic      [7:0] dir_o,
	output logic            db_clk_o
);
	logic [1:0] div_ff = 2'h0;

	// ****************************************
	// Pins change just after an edge
	// ****************************************
	always_ff @(posedge clk_i) begin
		pin_o <= lvl_i;
		dir_o <= dir_i;
		div_ff <= div_ff + 2'h1;
	end

	// Slow free-running debounce clock, unrelated to bus traffic
	assign db_clk_o = div_ff[1];
endmodule : pin_model

`default_nettype wire

// [tb/gpio_interrupt_config_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module gpio_interrupt_config_tb;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        we_i  = 1'b0;
	logic [7:0]  adr_i = 8'h00;
	logic [3:0]  sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o;
	logic [31:0] rd;
	logic        ack_o;
	logic        db_clk_i;
	logic        irq_o;
	logic [7:0]  port_a_i;
	logic [7:0]  port_a_dir_i;
	logic [7:0]  port_d_dir_o;
	logic [7:0]  edge_clear_o;
	logic [7:0]  raw_status_o;
	logic [7:0]  masked_status_o;
	logic [7:0]  lvl = 8'h00;
	logic [7:0]  dir = 8'h00;
	logic [7:0]  clr_seen = 8'h00;
	logic [7:0]  ofs [5] = '{8'h28, 8'h30, 8'h34, 8'h38, 8'h3c};
	int          errors = 0;
	int          checked = 0;

	always #10 clk_i = ~clk_i;
	// Clear pulse lasts one cycle, so catch it here
	always @(posedge clk_i) if (edge_clear_o !== 8'h00) clr_seen <= edge_clear_o;

	pin_model pm (.clk_i(clk_i), .lvl_i(lvl), .dir_i(dir), .pin_o(port_a_i),
		.dir_o(port_a_dir_i), .db_clk_o(db_clk_i));

	gpio_interrupt_config uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .port_a_i(port_a_i),
		.port_a_dir_i(port_a_dir_i), .db_clk_i(db_clk_i),
		.port_d_dir_o(port_d_dir_o), .edge_clear_o(edge_clear_o),
		.raw_status_o(raw_status_o), .masked_status_o(masked_status_o),
		.irq_o(irq_o));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic results;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hf;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		if (n >= 20) begin
			chk("ack", 32'h1, 32'h0);
			errors++;
			results();
		end
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask : wb

	task automatic pins(input logic [7:0] l, input logic [7:0] dr);
		@(posedge clk_i);
		lvl <= l;
		dir <= dr;
		repeat (4) @(posedge clk_i);
	endtask : pins

	task automatic sts(input logic [7:0] r, input logic [7:0] m);
		// Status follows a config write one cycle late
		repeat (2) @(posedge clk_i);
		chk("raw", {24'h0, r}, {24'h0, raw_status_o});
		chk("masked", {24'h0, m}, {24'h0, masked_status_o});
		chk("irq", {31'h0, |m}, {31'h0, irq_o});
		wb(1'b0, 8'h44, 32'h0);
		chk("raw_reg", {24'h0, r}, rd);
		wb(1'b0, 8'h40, 32'h0);
		chk("masked_reg", {24'h0, m}, rd);
	endtask : sts

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		foreach (ofs[i]) begin
			wb(1'b0, ofs[i], 32'h0);
			chk("reset_val", 32'h0, rd);
		end
		chk("dir_d", 32'h0, {24'h0, port_d_dir_o});
		sts(8'h00, 8'h00);
	endtask : t_reset

	task automatic t_regs;
		foreach (ofs[i]) begin
			wb(1'b1, ofs[i], 32'hffffff5a);
			wb(1'b0, ofs[i], 32'h0);
			chk("readback", 32'h5a, rd);
		end
		chk("dir_d", 32'h5a, {24'h0, port_d_dir_o});
		wb(1'b0, 8'h50, 32'h0);
		chk("unmapped", 32'h0, rd);
		foreach (ofs[i]) wb(1'b1, ofs[i], 32'h0);
		chk("dir_d", 32'h0, {24'h0, port_d_dir_o});
	endtask : t_regs

	task automatic t_level;
		wb(1'b1, 8'h30, 32'h1);
		pins(8'h01, 8'h00);
		sts(8'h00, 8'h00);
		pins(8'h00, 8'h00);
		sts(8'h01, 8'h01);
		wb(1'b1, 8'h3c, 32'h1);
		pins(8'h01, 8'h00);
		sts(8'h01, 8'h01);
		wb(1'b1, 8'h34, 32'h1);
		sts(8'h01, 8'h00);
		wb(1'b1, 8'h34, 32'h0);
		pins(8'h01, 8'h01);
		sts(8'h00, 8'h00);
		pins(8'h01, 8'h00);
		wb(1'b1, 8'h30, 32'h0);
		sts(8'h00, 8'h00);
	endtask : t_level

	task automatic t_edge;
		pins(8'h00, 8'h00);
		wb(1'b1, 8'h30, 32'h1);
		wb(1'b1, 8'h38, 32'h1);
		sts(8'h00, 8'h00);
		pins(8'h01, 8'h00);
		pins(8'h00, 8'h00);
		sts(8'h01, 8'h01);
		wb(1'b1, 8'h4c, 32'h0);
		sts(8'h01, 8'h01);
		wb(1'b1, 8'h4c, 32'h1);
		sts(8'h00, 8'h00);
		chk("clear_pulse", 32'h1, {24'h0, clr_seen});
		wb(1'b1, 8'h3c, 32'h0);
		pins(8'h01, 8'h00);
		sts(8'h00, 8'h00);
		pins(8'h00, 8'h00);
		sts(8'h01, 8'h01);
		wb(1'b1, 8'h30, 32'h0);
		sts(8'h00, 8'h00);
	endtask : t_edge

	task automatic t_debounce;
		wb(1'b1, 8'h38, 32'h0);
		wb(1'b1, 8'h48, 32'h1);
		wb(1'b1, 8'h3c, 32'h1);
		pins(8'h00, 8'h00);
		repeat (16) @(posedge clk_i);
		wb(1'b1, 8'h30, 32'h1);
		sts(8'h00, 8'h00);
		pins(8'h01, 8'h00);
		chk("debounced", 32'h0, {24'h0, raw_status_o});
		repeat (16) @(posedge clk_i);
		sts(8'h01, 8'h01);
		wb(1'b1, 8'h30, 32'h0);
		sts(8'h00, 8'h00);
	endtask : t_debounce

	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_regs();
		t_level();
		t_edge();
		t_debounce();
		results();
	end

	// Whole run needs well under a thousand cycles
	initial begin
		repeat (4000) @(posedge clk_i);
		errors++;
		results();
	end
endmodule : gpio_interrupt_config_tb

`default_nettype wire
